// *** core/csram_pkg.sv ***
package csram_pkg;
	// array geometry, wide variant: 4096 single-bit words
	localparam int          ADDR_W         = 12;
	localparam int          DATA_W         = 1;
	localparam int          DEPTH          = 4096;
	localparam int          NARROW_ADDR_W  = 10;
	localparam int          NARROW_DEPTH   = 1024;

	// sampled pin vector layout
	localparam int          PIN_W          = 18;
	localparam int          POS_STROBE     = 0;
	localparam int          POS_SEL_N      = 1;
	localparam int          POS_WR_N       = 2;
	localparam int          POS_OUT_ON     = 3;
	localparam int          POS_OUT_OFF    = 4;
	localparam int          POS_DIN        = 5;
	localparam int          POS_ADDR       = 6;

	// internal self-timed intervals
	localparam int          CLK_PERIOD_NS  = 10;
	localparam int          ACCESS_TIME_NS = 50;
	localparam int          PRESET_TIME_NS = 30;
	localparam int          ACCESS_CYC     = (ACCESS_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int          PRESET_CYC     = (PRESET_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int          CNT_W          = 8;
	localparam logic [7:0]  ACCESS_LOAD    = 8'(ACCESS_CYC - 1);
	localparam logic [7:0]  PRESET_LOAD    = 8'(PRESET_CYC - 1);

	// reset values
	localparam logic [17:0] PIN_RST        = 18'h0001E;
	localparam logic [11:0] ADDR_RST       = 12'h000;

	typedef enum logic [2:0] {
		st_unpreset,
		st_preset,
		st_idle,
		st_decode,
		st_active
	} cycle_state_e;
endpackage

// *** core/clocked_static_ram_interface.sv ***
module clocked_static_ram_interface
	import csram_pkg::*;
(
	input  wire logic                    clk_sys,      // system clock, 100 MHz
	input  wire logic                    nrst,         // async reset, active low
	input  wire logic                    cycle_strobe, // cycle strobe pin
	input  wire logic                    sel_n,        // chip select pin, active low
	input  wire logic                    wr_n,         // write strobe pin, active low
	input  wire logic                    output_on,    // output enable pin
	input  wire logic                    output_off,   // output disable pin
	input  wire logic [csram_pkg::ADDR_W-1:0] addr_lines, // word address pins
	input  wire logic [csram_pkg::DATA_W-1:0] data_in,    // write data pin
	output logic      [csram_pkg::DATA_W-1:0] data_out,   // read data pin
	output logic                         data_oe_n,    // low while data_out drives
	output logic                         ready_flag    // self-timed status
);
	import csram_pkg::*;

	logic [PIN_W-1:0]  pin_s1_reg;
	logic [PIN_W-1:0]  pin_s2_reg;
	logic [PIN_W-1:0]  pin_s3_reg;
	logic [PIN_W-1:0]  pin_f_reg;
	logic [PIN_W-1:0]  pin_f_next;
	logic [PIN_W-1:0]  pin_raw;
	logic              strobe_f;
	logic              strobe_q_reg;
	logic              sel_n_f;
	logic              wr_n_f;
	logic              on_f;
	logic              off_f;
	logic [DATA_W-1:0] din_f;
	logic [ADDR_W-1:0] addr_f;
	logic              rise_evt;
	logic              fall_evt;
	cycle_state_e      state_reg;
	cycle_state_e      state_next;
	logic [CNT_W-1:0]  cnt_reg;
	logic [CNT_W-1:0]  cnt_next;
	logic              cnt_zero;
	logic [ADDR_W-1:0] addr_reg;
	logic              sel_reg;
	logic [DATA_W-1:0] dout_reg;
	logic              valid_reg;
	logic              ready_reg;
	logic              oe_n_reg;
	logic              mem_we;
	logic              access_done;
	logic              preset_done;
	logic              buf_on;
	logic [DATA_W-1:0] mem [DEPTH];

	// accept a pin change once two sampled stages agree
	function automatic logic [PIN_W-1:0] agree_filter(
		input logic [PIN_W-1:0] s2,
		input logic [PIN_W-1:0] s3,
		input logic [PIN_W-1:0] held
	);
		agree_filter = (s2 & s3) | (held & (s2 ^ s3));
	endfunction

	// one step down of the self-timed interval counter
	function automatic logic [CNT_W-1:0] dec_count(
		input logic [CNT_W-1:0] c
	);
		dec_count = c - 8'h01;
	endfunction

	// all pins share one chain so address and strobe stay aligned
	assign pin_raw    = {addr_lines, data_in, output_off, output_on, wr_n, sel_n, cycle_strobe};
	assign pin_f_next = agree_filter(pin_s2_reg, pin_s3_reg, pin_f_reg);

	// three-stage sampling of asynchronous pins
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			pin_s1_reg <= PIN_RST;
			pin_s2_reg <= PIN_RST;
			pin_s3_reg <= PIN_RST;
			pin_f_reg  <= PIN_RST;
		end else begin
			pin_s1_reg <= pin_raw;
			pin_s2_reg <= pin_s1_reg;
			pin_s3_reg <= pin_s2_reg;
			pin_f_reg  <= pin_f_next;
		end
	end

	// filtered pin fields
	assign strobe_f = pin_f_reg[POS_STROBE];
	assign sel_n_f  = pin_f_reg[POS_SEL_N];
	assign wr_n_f   = pin_f_reg[POS_WR_N];
	assign on_f     = pin_f_reg[POS_OUT_ON];
	assign off_f    = pin_f_reg[POS_OUT_OFF];
	assign din_f    = pin_f_reg[POS_DIN +: DATA_W];
	assign addr_f   = pin_f_reg[POS_ADDR +: ADDR_W];

	// strobe edges; only a rise in idle counts, an earlier rise is dropped, a fall is taken in any state
	assign rise_evt = strobe_f & ~strobe_q_reg & (state_reg == st_idle);
	assign fall_evt = ~strobe_f & strobe_q_reg;

	// internal timing milestones
	assign cnt_zero    = (cnt_reg == '0);
	assign access_done = (state_reg == st_decode) & cnt_zero & strobe_f;
	assign preset_done = (state_reg == st_preset) & cnt_zero;

	// cell write: selected, strobe high, write low, address decoded
	assign mem_we = (state_reg == st_active) & strobe_f & sel_reg & ~wr_n_f;

	// buffer gating ignores the write strobe entirely
	assign buf_on = sel_reg & on_f & ~off_f & valid_reg;

	// cycle sequencer; only preset and decode end on the counter, so the strobe may stop anywhere
	always_comb begin
		state_next = state_reg;
		cnt_next   = cnt_reg;
		case (state_reg)
			st_unpreset: begin
				if (!strobe_f) begin
					state_next = st_preset;
					cnt_next   = PRESET_LOAD;
				end
			end
			st_preset: begin
				if (cnt_zero) begin
					state_next = st_idle;
				end else begin
					cnt_next = dec_count(cnt_reg);
				end
			end
			st_idle: begin
				if (rise_evt) begin
					state_next = st_decode;
					cnt_next   = ACCESS_LOAD;
				end
			end
			st_decode: begin
				if (fall_evt) begin
					state_next = st_preset;
					cnt_next   = PRESET_LOAD;
				end else if (cnt_zero) begin
					state_next = st_active;
				end else begin
					cnt_next = dec_count(cnt_reg);
				end
			end
			st_active: begin
				if (fall_evt) begin
					state_next = st_preset;
					cnt_next   = PRESET_LOAD;
				end
			end
			default: begin
				state_next = st_unpreset;
				cnt_next   = '0;
			end
		endcase
	end

	// sequencer registers
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			state_reg    <= st_unpreset;
			cnt_reg      <= '0;
			strobe_q_reg <= 1'b0;
		end else begin
			state_reg    <= state_next;
			cnt_reg      <= cnt_next;
			strobe_q_reg <= strobe_f;
		end
	end

	// address and select register, loaded only at cycle start
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			addr_reg <= ADDR_RST;
			sel_reg  <= 1'b0;
		end else if (rise_evt) begin
			addr_reg <= addr_f;
			sel_reg  <= ~sel_n_f;
		end
	end

	// output latch: cleared at rise, loaded at access, held through preset
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			dout_reg  <= '0;
			valid_reg <= 1'b0;
		end else if (rise_evt) begin
			dout_reg  <= '0;
			valid_reg <= 1'b0;
		end else if (mem_we) begin
			dout_reg  <= din_f;
			valid_reg <= 1'b1;
		end else if (access_done) begin
			dout_reg  <= mem[addr_reg];
			valid_reg <= 1'b1;
		end
	end

	// cell array; a write running every cycle keeps the latest data
	always_ff @(posedge clk_sys) begin
		if (mem_we) begin
			mem[addr_reg] <= din_f;
		end
	end

	// status flag and buffer enable registers
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			ready_reg <= 1'b0;
			oe_n_reg  <= 1'b1;
		end else begin
			if (access_done) begin
				ready_reg <= 1'b1;
			end else if (preset_done) begin
				ready_reg <= 1'b0;
			end
			oe_n_reg <= ~(buf_on & ~rise_evt);
		end
	end

	assign data_out   = dout_reg;
	assign data_oe_n  = oe_n_reg;
	assign ready_flag = ready_reg;

	localparam int PRESET_MAX = 8;
	localparam int ACCESS_MAX = 12;

	property p_rise_starts;
		@(posedge clk_sys) disable iff (!nrst)
		rise_evt |=> (state_reg == st_decode) && (addr_reg == $past(addr_f));
	endproperty
	a_rise_starts: assert property (p_rise_starts) else $error("cycle did not start");

	property p_addr_hold;
		@(posedge clk_sys) disable iff (!nrst)
		!rise_evt |=> $stable(addr_reg) && $stable(sel_reg);
	endproperty
	a_addr_hold: assert property (p_addr_hold) else $error("address changed mid cycle");

	property p_desel_off;
		@(posedge clk_sys) disable iff (!nrst)
		!sel_reg |=> data_oe_n;
	endproperty
	a_desel_off: assert property (p_desel_off) else $error("deselected chip drives");

	property p_ctrl_off;
		@(posedge clk_sys) disable iff (!nrst)
		(!on_f || off_f) |=> data_oe_n;
	endproperty
	a_ctrl_off: assert property (p_ctrl_off) else $error("output controls ignored");

	property p_rise_clear;
		@(posedge clk_sys) disable iff (!nrst)
		rise_evt |=> !valid_reg && data_oe_n && (data_out == '0);
	endproperty
	a_rise_clear: assert property (p_rise_clear) else $error("latch not cleared");

	property p_write_gate;
		@(posedge clk_sys) disable iff (!nrst)
		mem_we |-> strobe_f && sel_reg && !wr_n_f;
	endproperty
	a_write_gate: assert property (p_write_gate) else $error("illegal write");

	property p_early_write;
		@(posedge clk_sys) disable iff (!nrst)
		(rise_evt && !wr_n_f) |=> !mem_we;
	endproperty
	a_early_write: assert property (p_early_write) else $error("write before decode");

	property p_write_echo;
		@(posedge clk_sys) disable iff (!nrst)
		mem_we |=> (data_out == $past(din_f)) && valid_reg;
	endproperty
	a_write_echo: assert property (p_write_echo) else $error("output not write data");

	property p_ready_rise;
		@(posedge clk_sys) disable iff (!nrst)
		(rise_evt ##1 strobe_f[*5]) |-> ##[0:ACCESS_MAX] ready_flag;
	endproperty
	a_ready_rise: assert property (p_ready_rise) else $error("ready flag late");

	property p_ready_fall;
		@(posedge clk_sys) disable iff (!nrst)
		(fall_evt && state_reg == st_active) |-> ##[1:PRESET_MAX] !ready_flag;
	endproperty
	a_ready_fall: assert property (p_ready_fall) else $error("preset never ended");

	property p_ctrl_on;
		@(posedge clk_sys) disable iff (!nrst)
		(sel_reg && on_f && !off_f && valid_reg && !rise_evt) |=> !data_oe_n;
	endproperty
	a_ctrl_on: assert property (p_ctrl_on) else $error("enabled buffer stayed off");

	property p_wr_keeps_oe;
		@(posedge clk_sys) disable iff (!nrst)
		(!wr_n_f && buf_on && !rise_evt) |=> !data_oe_n;
	endproperty
	a_wr_keeps_oe: assert property (p_wr_keeps_oe) else $error("write turned buffer off");

	property p_data_hold;
		@(posedge clk_sys) disable iff (!nrst)
		((state_reg == st_preset || state_reg == st_idle) && !rise_evt) |=> $stable(data_out);
	endproperty
	a_data_hold: assert property (p_data_hold) else $error("held data changed");

	property p_ready_hold;
		@(posedge clk_sys) disable iff (!nrst)
		(ready_flag && strobe_f && state_reg == st_active) |=> ready_flag;
	endproperty
	a_ready_hold: assert property (p_ready_hold) else $error("ready flag dropped early");

	c_read: cover property (@(posedge clk_sys) disable iff (!nrst)
		access_done && wr_n_f ##2 !data_oe_n);
	c_early_write: cover property (@(posedge clk_sys) disable iff (!nrst)
		rise_evt && !wr_n_f ##[1:20] mem_we);
	c_write: cover property (@(posedge clk_sys) disable iff (!nrst)
		mem_we ##1 fall_evt);
	c_back_to_back: cover property (@(posedge clk_sys) disable iff (!nrst)
		preset_done ##[1:20] rise_evt);
endmodule

// *** sim/ctrl_model.sv ***
module ctrl_model
	import csram_pkg::*;
(
	input  wire logic                    clk_sys,      // system clock
	input  wire logic                    ready_flag,   // status from the memory
	output logic                         cycle_strobe, // cycle strobe
	output logic                         sel_n,        // chip select, active low
	output logic                         wr_n,         // write strobe, active low
	output logic                         output_on,    // output enable
	output logic                         output_off,   // output disable
	output logic [csram_pkg::ADDR_W-1:0] addr_lines,   // word address
	output logic [csram_pkg::DATA_W-1:0] data_in       // write data
);
	timeunit 1ns;
	timeprecision 1ps;

	// strobe low from time zero performs the initial preset
	initial begin
		cycle_strobe = 1'b0;
		sel_n = 1'b1;
		wr_n = 1'b1;
		output_on = 1'b1;
		output_off = 1'b0;
		addr_lines = '0;
		data_in = '0;
	end

	// bounded wait so a dead status output cannot hang the controller
	task automatic wait_ready(input logic lvl);
		for (int i = 0; i < 60 && ready_flag !== lvl; i++) @(negedge clk_sys);
	endtask

	// one whole cycle; write data switches to late_din before the end
	task automatic run(input logic [ADDR_W-1:0] a, input logic sn, input logic wr,
		input logic [DATA_W-1:0] din, input logic [DATA_W-1:0] late_din,
		input logic on, input logic off, input int stretch, input logic low_wr);
		@(negedge clk_sys);
		addr_lines = a;
		sel_n = sn;
		wr_n = ~wr; // held high while the strobe is high in a read; low_wr sets it after the strobe drops
		data_in = din;
		output_on = on;
		output_off = off;
		cycle_strobe = 1'b1;
		repeat (8) @(negedge clk_sys);
		addr_lines = ~a; // captured already, must be ignored now
		sel_n = ~sn;
		wait_ready(1'b1);
		data_in = late_din;
		repeat (stretch) @(negedge clk_sys); // strobe kept high after access
		cycle_strobe = 1'b0;
		wr_n = low_wr; // don't care while the strobe is low
		data_in = ~late_din; // zero hold after termination
		wait_ready(1'b0); // no new rise before preset is done
	endtask
endmodule

// *** sim/clocked_static_ram_interface_tb.sv ***
module clocked_static_ram_interface_tb
	import csram_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	typedef struct packed {
		logic [DATA_W-1:0] data;
		logic              care;
		logic              oe_n;
	} note_s;

	logic              clk_sys, nrst, cycle_strobe, sel_n, wr_n, output_on, output_off;
	logic              data_oe_n, ready_flag;
	logic [ADDR_W-1:0] addr_lines;
	logic [DATA_W-1:0] data_in, data_out;
	logic [DATA_W-1:0] mem [DEPTH];
	logic [ADDR_W-1:0] la [8];
	note_s             notes [$];
	int                fail_count = 0;
	int                samples_checked = 0;
	integer            seed = 48;

	// free-running system clock
	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end

	clocked_static_ram_interface u_clocked_static_ram_interface (
		.clk_sys(clk_sys), .nrst(nrst), .cycle_strobe(cycle_strobe), .sel_n(sel_n),
		.wr_n(wr_n), .output_on(output_on), .output_off(output_off),
		.addr_lines(addr_lines), .data_in(data_in), .data_out(data_out),
		.data_oe_n(data_oe_n), .ready_flag(ready_flag));

	ctrl_model u_ctrl_model (
		.clk_sys(clk_sys), .ready_flag(ready_flag), .cycle_strobe(cycle_strobe),
		.sel_n(sel_n), .wr_n(wr_n), .output_on(output_on), .output_off(output_off),
		.addr_lines(addr_lines), .data_in(data_in));

	task automatic check_oe(input logic exp, input logic got);
		samples_checked++;
		if (got !== exp) begin
			fail_count++;
			$display("BAD data_oe_n expected %b seen %b", exp, got);
		end
	endtask

	task automatic check_data(input logic [DATA_W-1:0] exp, input logic [DATA_W-1:0] got);
		samples_checked++;
		if (got !== exp) begin
			fail_count++;
			$display("BAD data_out expected %h seen %h", exp, got);
		end
	endtask

	task automatic check_ready(input int exp, input int got);
		samples_checked++;
		if (got != exp) begin
			fail_count++;
			$display("BAD ready_flag delay expected %0d seen %0d", exp, got);
		end
	endtask

	task automatic end_sim();
		$display("comparisons %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	// note the expected result, then let the controller run the cycle
	task automatic op(input logic [ADDR_W-1:0] a, input logic sel, input logic wr,
		input logic on, input logic off, input int stretch, input logic low_wr);
		note_s             n;
		logic [DATA_W-1:0] d0, d1;
		d0 = DATA_W'($random(seed));
		d1 = DATA_W'($random(seed));
		n.oe_n = !(sel && on && !off);
		n.care = sel;
		n.data = wr ? d1 : mem[a];
		if (sel && wr) mem[a] = d1; // deselected writes are refused
		notes.push_back(n);
		u_ctrl_model.run(a, ~sel, wr, d0, d1, on, off, stretch, low_wr);
	endtask

	// status delay counted from strobe rise; buffer is enabled one clock after status
	initial begin
		note_s n;
		int    cyc;
		forever begin
			@(posedge cycle_strobe);
			cyc = 0;
			while (ready_flag !== 1'b1 && cyc < 60) begin
				@(negedge clk_sys);
				cyc++;
			end
			n = notes[0];
			// four clocks of pin sampling plus the start edge, then the access
			check_ready(5 + ACCESS_CYC, cyc);
			@(negedge clk_sys);
			check_oe(n.oe_n, data_oe_n);
			@(negedge ready_flag);
			@(negedge clk_sys);
			n = notes.pop_front();
			if (n.care) check_data(n.data, data_out);
		end
	end

	// a hung cycle counts as a mismatch
	initial begin
		#100000;
		fail_count++;
		end_sim();
	end

	initial begin
		nrst = 1'b0;
		la = '{12'h000, 12'hFFF, 12'h555, 12'hAAA, 12'h001, 12'h800, 12'h7FF, 12'h3C3};
		repeat (12) @(negedge clk_sys);
		nrst = 1'b1;
		repeat (12) @(negedge clk_sys);
		// write strobe left low across the whole run of writes
		for (int i = 0; i < 8; i++) op(la[i], 1'b1, 1'b1, 1'b1, 1'b0, 4 + i, 1'b0);
		// read back with a random write strobe during every low phase
		for (int i = 0; i < 8; i++) op(la[i], 1'b1, 1'b0, 1'b1, 1'b0, i % 3, 1'($random(seed)));
		// deselected write must leave the cell alone
		op(la[0], 1'b0, 1'b1, 1'b1, 1'b0, 4, 1'b1);
		op(la[0], 1'b1, 1'b0, 1'b1, 1'b0, 2, 1'b1);
		// every combination of the two output controls
		for (int i = 0; i < 4; i++) op(la[1], 1'b1, 1'b0, i[1], i[0], 1, 1'b1);
		// output-on tied to the write strobe, as on shared data lines
		op(la[3], 1'b1, 1'b1, 1'b0, 1'b0, 4, 1'b0);
		// deselected read keeps the buffer off
		op(la[2], 1'b0, 1'b0, 1'b1, 1'b0, 2, 1'b1);
		// let the last check finish; an unanswered note is a lost cycle
		repeat (4) @(negedge clk_sys);
		if (notes.size() != 0) begin
			fail_count++;
			$display("BAD pending notes expected 0 seen %0d", notes.size());
		end
		end_sim();
	end
endmodule
